// ### event_sel_pkg.sv
// register map, field layout and reset mappings of the event selector
`default_nettype none
package event_sel_pkg;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int INT_SEL_W  = 5;
	localparam int XFER_SEL_W = 6;
	localparam int INT_LINES  = 16;
	localparam int INT_MAPPED = 12;
	localparam int INT_PER_REG = 6;
	localparam int XFER_CHANS = 16;
	localparam int XFER_MAPPED = 12;
	localparam int XFER_PER_REG = 4;
	localparam int XFER_FIELD_STRIDE = 8;
	localparam int GPIO_PINS  = 16;
	localparam int EXT_IRQS   = 4;
	localparam int EXT_PIN_LSB = 4;
	localparam int CHAIN_CHANS = 4;
	// meta, sync and history stages that must fill before edges count
	localparam int PIN_FILL_W  = 3;

	localparam logic [ADDR_W-1:0] INT_SEL_HIGH_ADDR  = 32'h019C_0000;
	localparam logic [ADDR_W-1:0] INT_SEL_LOW_ADDR   = 32'h019C_0004;
	localparam logic [ADDR_W-1:0] EXT_POL_ADDR       = 32'h019C_0008;
	localparam logic [ADDR_W-1:0] GPIO_COMB_EN_ADDR  = 32'h019C_000C;
	localparam logic [ADDR_W-1:0] PIN_LEVEL_ADDR     = 32'h019C_0010;
	localparam logic [ADDR_W-1:0] XFER_SEL_A_ADDR    = 32'h01A0_FF00;
	localparam logic [ADDR_W-1:0] XFER_SEL_B_ADDR    = 32'h01A0_FF04;
	localparam logic [ADDR_W-1:0] XFER_SEL_D_ADDR    = 32'h01A0_FF0C;

	// lsb of each line field inside its selector word
	localparam int INT_FIELD_LSB [INT_PER_REG] = '{0, 5, 10, 16, 21, 26};

	// defaults for lines 4..15 in order
	localparam logic [INT_SEL_W-1:0] INT_SEL_DEFAULT [INT_MAPPED] = '{
		5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
		5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};

	// channel served by each mappable field; reset code equals channel
	localparam int XFER_CHANNEL [XFER_MAPPED] = '{
		0, 1, 2, 3, 4, 5, 6, 7, 12, 13, 14, 15};
	localparam logic [ADDR_W-1:0] XFER_ADDR [XFER_MAPPED/XFER_PER_REG] = '{
		XFER_SEL_A_ADDR, XFER_SEL_B_ADDR, XFER_SEL_D_ADDR};

	localparam logic [EXT_IRQS-1:0]  EXT_POL_RESET     = 4'h0;
	localparam logic [GPIO_PINS-1:0] GPIO_COMB_EN_RESET = 16'h0000;
endpackage
`default_nettype wire

// ### event_interrupt_selector.sv
// interrupt selector and transfer event selector with register port
//
// How it works
// RL1: sixteen prioritized lines, line 0 reset
// RL2: lines 0-3 fixed, no selector field
// RL3: lines 4-15 from resettable selector fields
// RL4: two selector words at printed addresses
// RL5: low word fields lines 4-9, defaults
// RL6: high word fields lines 10-15, defaults
// RL7: low interrupt codes decode to listed sources
// RL8: upper codes: combined pin, two-wire, audio
// RL9: pins 4-7 edge events, polarity bits 3:0
// RL10: software enables pins 4-7 as inputs first
// RL11: all sixteen pins feed combined event
// RL12: sixteen channels, 8-11 chaining, unmapped
// RL13: three transfer selector words at addresses
// RL14: four 6-bit fields, default channel number
// RL15: channels 12-15 default serial sync codes
// RL16: low transfer codes decode as listed
// RL17: audio codes six events per port
// RL18: two-wire sync and pins 8-15 codes
// RL19: reserved transfer codes select nothing
// RL20: written code routes event to channel
// RL21: transfer reserved bits read zero
// RL22: reserved codes inactive; bits 15,31 zero
`default_nettype none
module event_interrupt_selector (
	input  wire logic                              mclk,           // clock
	input  wire logic                              rst_n,          // sync reset
	input  wire logic [event_sel_pkg::ADDR_W-1:0]  busAddr,        // byte address
	input  wire logic [event_sel_pkg::DATA_W-1:0]  busWrData,      // write data
	input  wire logic                              busWrEn,        // write strobe
	input  wire logic                              busRdEn,        // read strobe
	output logic      [event_sel_pkg::DATA_W-1:0]  busRdData,      // read data
	input  wire logic                              resetReq,       // line 0 source
	input  wire logic                              nmiReq,         // line 1 source
	input  wire logic                              hostPortEvent,  // host port
	input  wire logic                              timerAEvent,    // timer 0
	input  wire logic                              timerBEvent,    // timer 1
	input  wire logic                              memifEvent,     // memory if
	input  wire logic                              xferEngineIrq,  // engine done
	input  wire logic                              emulDmaEvent,   // emulation
	input  wire logic                              emulRxEvent,    // emulation
	input  wire logic                              emulTxEvent,    // emulation
	input  wire logic [3:0]                        serportIrq,     // atx arx btx brx
	input  wire logic [3:0]                        serportSync,    // atx arx btx brx
	input  wire logic [1:0]                        twowireIrq,     // a, b
	input  wire logic [3:0]                        twowireSync,    // arx atx brx btx
	input  wire logic [3:0]                        audioIrq,       // atx arx btx brx
	input  wire logic [11:0]                       audioSync,      // six per port
	input  wire logic [event_sel_pkg::GPIO_PINS-1:0] gpioPin,      // async pins
	input  wire logic [event_sel_pkg::CHAIN_CHANS-1:0] chainTrigger, // ch 8-11
	output logic      [event_sel_pkg::INT_LINES-1:0] cpuIrq,       // to core
	output logic      [event_sel_pkg::XFER_CHANS-1:0] xferTrigger  // to engine
);
	import event_sel_pkg::*;

	logic [GPIO_PINS-1:0]  pinMeta;
	logic [GPIO_PINS-1:0]  pinSync;
	logic [GPIO_PINS-1:0]  pinPrev;
	logic [GPIO_PINS-1:0]  pinEvt;
	logic [PIN_FILL_W-1:0] pinFill_reg;
	logic                  wrIntLow;
	logic                  wrIntHigh;
	logic                  wrExtPol;
	logic                  wrCombEn;
	logic [XFER_MAPPED/XFER_PER_REG-1:0] wrXferWord;
	logic [EXT_IRQS-1:0]   ext_irq_polarity_reg;
	logic [GPIO_PINS-1:0]  combEn_reg;
	logic                  gpioCombined;
	logic [31:0]           intSrc;
	logic [63:0]           xferSrc;
	logic [INT_SEL_W-1:0]  intSel [INT_MAPPED];
	logic [XFER_SEL_W-1:0] xferSel [XFER_MAPPED];
	logic [INT_MAPPED-1:0] intLine_reg;
	logic [XFER_MAPPED-1:0] chanTrig_reg;
	logic [3:0]            fixedLine_reg;
	logic [CHAIN_CHANS-1:0] chain_reg;
	logic [DATA_W-1:0]     intLowWord;
	logic [DATA_W-1:0]     intHighWord;
	logic [DATA_W-1:0]     xferWord [XFER_MAPPED/XFER_PER_REG];
	logic [DATA_W-1:0]     busRdData_next;

	// pins are asynchronous; only the second and third stages feed the edge logic
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinMeta <= '0;
			pinSync <= '0;
			pinPrev <= '0;
		end else begin
			pinMeta <= gpioPin;
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	// the stages leave reset at zero; a pin idling high would look like
	// a rising edge until the history flop holds a real sample
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinFill_reg <= '0;
		end else begin
			pinFill_reg <= {pinFill_reg[PIN_FILL_W-2:0], 1'b1};
		end
	end

	// one hit per register; exact address match, other writes are dropped
	always_comb begin
		wrIntLow  = busWrEn && (busAddr == INT_SEL_LOW_ADDR);
		wrIntHigh = busWrEn && (busAddr == INT_SEL_HIGH_ADDR);
		wrExtPol  = busWrEn && (busAddr == EXT_POL_ADDR);
		wrCombEn  = busWrEn && (busAddr == GPIO_COMB_EN_ADDR);
		for (int r = 0; r < XFER_MAPPED/XFER_PER_REG; r++) begin
			wrXferWord[r] = busWrEn && (busAddr == XFER_ADDR[r]);
		end
	end

	// external polarity: 0 rising edge, 1 falling edge
	always_comb begin
		pinEvt = pinSync & ~pinPrev;
		for (int p = 0; p < EXT_IRQS; p++) begin
			if (ext_irq_polarity_reg[p]) begin
				pinEvt[EXT_PIN_LSB+p] = ~pinSync[EXT_PIN_LSB+p] & // RL9
					pinPrev[EXT_PIN_LSB+p];
			end
		end
		if (!pinFill_reg[PIN_FILL_W-1]) begin
			pinEvt = '0;
		end
	end

	// any enabled pin may raise the combined event
	assign gpioCombined = |(pinEvt & combEn_reg); // RL11

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ext_irq_polarity_reg <= EXT_POL_RESET;
		end else if (wrExtPol) begin
			ext_irq_polarity_reg <= busWrData[EXT_IRQS-1:0]; // RL9
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			combEn_reg <= GPIO_COMB_EN_RESET;
		end else if (wrCombEn) begin
			combEn_reg <= busWrData[GPIO_PINS-1:0];
		end
	end

	// index equals selector code; reserved codes are tied inactive
	assign intSrc = {
		audioIrq,                                   // RL8
		4'h0,                                       // RL22
		twowireIrq,                                 // RL8
		5'h00,                                      // RL22
		gpioCombined,                               // RL8
		serportIrq,                                 // RL7
		emulTxEvent, emulRxEvent, emulDmaEvent,     // RL7
		xferEngineIrq,                              // RL7
		pinEvt[7:4],                                // RL7
		memifEvent, timerBEvent, timerAEvent, hostPortEvent}; // RL7

	assign xferSrc = {
		8'h00,                                      // RL19
		pinEvt[15:8],                               // RL18
		twowireSync,                                // RL18
		audioSync,                                  // RL17
		16'h0000,                                   // RL19
		serportSync,                                // RL16
		pinEvt[3:0],                                // RL16
		pinEvt[7:4],                                // RL16
		memifEvent, timerBEvent, timerAEvent, hostPortEvent}; // RL16

	// fixed lines 0-1 pass straight through, one register stage like the rest; lines 2-3 stay zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fixedLine_reg <= 4'h0;
		end else begin
			fixedLine_reg <= {2'b00, nmiReq, resetReq}; // RL2
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= chainTrigger; // RL12
		end
	end

	genvar g;
	generate
		for (g = 0; g < INT_MAPPED; g++) begin : gIntLine
			localparam int LSB = INT_FIELD_LSB[g % INT_PER_REG];
			logic wrHit;
			assign wrHit = (g < INT_PER_REG) ? wrIntLow : wrIntHigh;
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					intSel[g] <= INT_SEL_DEFAULT[g]; // RL3
				end else if (wrHit) begin
					intSel[g] <= busWrData[LSB +: INT_SEL_W]; // RL4
				end
			end
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					intLine_reg[g] <= 1'b0;
				end else begin
					intLine_reg[g] <= intSrc[intSel[g]]; // RL3
				end
			end
		end

		for (g = 0; g < XFER_MAPPED; g++) begin : gXferChan
			localparam int LSB = (g % XFER_PER_REG) * XFER_FIELD_STRIDE;
			localparam logic [XFER_SEL_W-1:0] RESET_CODE =
				XFER_SEL_W'(XFER_CHANNEL[g]);
			logic wrHit;
			assign wrHit = wrXferWord[g / XFER_PER_REG];
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					xferSel[g] <= RESET_CODE; // RL14 RL15
				end else if (wrHit) begin
					xferSel[g] <= busWrData[LSB +: XFER_SEL_W]; // RL13
				end
			end
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					chanTrig_reg[g] <= 1'b0;
				end else begin
					chanTrig_reg[g] <= xferSrc[xferSel[g]]; // RL20
				end
			end
		end
	endgenerate

	// line 0 is the highest priority; the core resolves priority by index
	assign cpuIrq = {intLine_reg, fixedLine_reg}; // RL1

	// channels 8-11 have no field and only carry the chain completions
	assign xferTrigger = {chanTrig_reg[XFER_MAPPED-1:8], chain_reg,
		chanTrig_reg[7:0]}; // RL12

	// assemble readback words; unused and reserved bits stay zero
	always_comb begin
		intLowWord  = '0;
		intHighWord = '0;
		for (int i = 0; i < INT_PER_REG; i++) begin
			intLowWord[INT_FIELD_LSB[i] +: INT_SEL_W]  = intSel[i]; // RL5
			intHighWord[INT_FIELD_LSB[i] +: INT_SEL_W] =
				intSel[i+INT_PER_REG]; // RL6
		end
	end

	always_comb begin
		for (int r = 0; r < XFER_MAPPED/XFER_PER_REG; r++) begin
			xferWord[r] = '0; // RL21
			for (int f = 0; f < XFER_PER_REG; f++) begin
				xferWord[r][f*XFER_FIELD_STRIDE +: XFER_SEL_W] =
					xferSel[r*XFER_PER_REG+f];
			end
		end
	end

	always_comb begin
		busRdData_next = '0;
		unique case (busAddr)
			INT_SEL_HIGH_ADDR: busRdData_next = intHighWord; // RL22
			INT_SEL_LOW_ADDR:  busRdData_next = intLowWord;
			EXT_POL_ADDR:      busRdData_next[EXT_IRQS-1:0] = ext_irq_polarity_reg;
			GPIO_COMB_EN_ADDR: busRdData_next[GPIO_PINS-1:0] = combEn_reg;
			PIN_LEVEL_ADDR:    busRdData_next[GPIO_PINS-1:0] = pinSync;
			XFER_SEL_A_ADDR:   busRdData_next = xferWord[0];
			XFER_SEL_B_ADDR:   busRdData_next = xferWord[1];
			XFER_SEL_D_ADDR:   busRdData_next = xferWord[2];
			default:           busRdData_next = '0;
		endcase
	end

	// data is held only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busRdData <= '0;
		end else if (busRdEn) begin
			busRdData <= busRdData_next;
		end else begin
			busRdData <= '0;
		end
	end
endmodule
`default_nettype wire

// ### xfer_engine_model.sv
// transfer engine stand-in: feeds chaining triggers back from triggers
`default_nettype none
module xfer_engine_model (
	input  wire logic        mclk,         // clock
	input  wire logic        rst_n,        // sync reset
	input  wire logic [15:0] xferTrigger,  // channel triggers
	output logic      [3:0]  chainTrigger  // completion chaining
);
	timeunit 1ns;
	timeprecision 100ps;
	// completion one cycle after a trigger on channels 0..3 chains to 8..11
	always_ff @(posedge mclk) begin
		chainTrigger <= rst_n ? xferTrigger[3:0] : 4'h0;
	end
endmodule
`default_nettype wire

// ### event_sel_checker.sv
// port assertions for the event interrupt selector
`default_nettype none
module event_sel_checker (
	input wire logic        mclk,         // clock
	input wire logic        rst_n,        // sync reset
	input wire logic [31:0] busAddr,      // address
	input wire logic        busRdEn,      // read strobe
	input wire logic [31:0] busRdData,    // read data
	input wire logic        resetReq,     // line 0 source
	input wire logic        nmiReq,       // line 1 source
	input wire logic [3:0]  chainTrigger, // chaining
	input wire logic [15:0] cpuIrq,       // lines
	input wire logic [15:0] xferTrigger   // triggers
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_line0;
		$past(rst_n, 2) |-> cpuIrq[0] == $past(resetReq);
	endproperty
	a_line0: assert property (p_line0) else $error("line 0 lost");
	property p_nmi;
		$past(rst_n, 2) |-> cpuIrq[1] == $past(nmiReq);
	endproperty
	a_nmi: assert property (p_nmi) else $error("line 1 lost");
	property p_fixed;
		cpuIrq[3:2] == 2'h0;
	endproperty
	a_fixed: assert property (p_fixed) else $error("lines 2-3 set");
	property p_chain;
		$past(rst_n, 2) |-> xferTrigger[11:8] == $past(chainTrigger);
	endproperty
	a_chain: assert property (p_chain) else $error("chain lost");
	property p_xres;
		$past(busRdEn) && $past(busAddr[31:4]) == 28'h01A0FF0
			|-> (busRdData & 32'hC0C0_C0C0) == 32'h0;
	endproperty
	a_xres: assert property (p_xres) else $error("xfer pad bits");
	property p_ires;
		$past(busRdEn) && $past(busAddr[31:3]) == 29'h0033_8000
			|-> !busRdData[15] && !busRdData[31];
	endproperty
	a_ires: assert property (p_ires) else $error("int pad bits");
	// data stand only in the cycle after the strobe
	property p_idle;
		$past(rst_n) && !$past(busRdEn) |-> busRdData == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("stale read data");
	property p_rstout;
		!$past(rst_n) |-> cpuIrq == 16'h0 && xferTrigger == 16'h0;
	endproperty
	a_rstout: assert property (p_rstout) else $error("out after reset");
endmodule
bind event_interrupt_selector event_sel_checker u_chk (.mclk, .rst_n,
	.busAddr, .busRdEn, .busRdData, .resetReq, .nmiReq, .chainTrigger,
	.cpuIrq, .xferTrigger);
`default_nettype wire

// ### event_interrupt_selector_tb.sv
// self-checking bench for the event interrupt selector
`default_nettype none
module event_interrupt_selector_tb;
	import event_sel_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk = 0, rst_n = 0, busWrEn = 0, busRdEn = 0;
	logic        resetReq = 0, nmiReq = 0;
	logic [31:0] busAddr = 0, busWrData = 0, iv = 0;
	logic [63:0] xv = 0;
	// pins arrive as enabled inputs of the outside pin module
	logic [15:0] gpioPin = 0;
	wire  [31:0] busRdData;
	wire  [3:0]  chainTrigger;
	wire  [15:0] cpuIrq, xferTrigger;
	int          err_total = 0, n_compared = 0;
	always #5 mclk = ~mclk;
	// iv is indexed by interrupt code, xv by transfer code
	event_interrupt_selector u_dut (.mclk, .rst_n, .busAddr, .busWrData,
		.busWrEn, .busRdEn, .busRdData, .resetReq, .nmiReq,
		.hostPortEvent(iv[0] | xv[0]), .timerAEvent(iv[1] | xv[1]),
		.timerBEvent(iv[2] | xv[2]), .memifEvent(iv[3] | xv[3]),
		.xferEngineIrq(iv[8]), .emulDmaEvent(iv[9]), .emulRxEvent(iv[10]),
		.emulTxEvent(iv[11]), .serportIrq(iv[15:12]),
		.serportSync(xv[15:12]), .twowireIrq(iv[23:22]),
		.twowireSync(xv[47:44]), .audioIrq(iv[31:28]),
		.audioSync(xv[43:32]), .gpioPin, .chainTrigger, .cpuIrq,
		.xferTrigger);
	xfer_engine_model u_eng (.mclk, .rst_n, .xferTrigger, .chainTrigger);
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		busAddr <= a;
		busWrData <= d;
		busWrEn <= 1'h1;
		@(posedge mclk);
		busWrEn <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [31:0] a, exp);
		busAddr <= a;
		busRdEn <= 1'h1;
		@(posedge mclk);
		busRdEn <= 1'h0;
		#1 chk(busRdData, exp);
		@(posedge mclk);
	endtask
	task automatic t_regs();
		rd(INT_SEL_HIGH_ADDR, 32'h0820_2D43);
		rd(INT_SEL_LOW_ADDR, 32'h2507_18A4);
		rd(XFER_SEL_A_ADDR, 32'h0302_0100);
		rd(XFER_SEL_B_ADDR, 32'h0706_0504);
		rd(XFER_SEL_D_ADDR, 32'h0F0E_0D0C);
		rd(32'h01A0_FF08, 32'h0);
		wr(XFER_SEL_A_ADDR, '1);
		rd(XFER_SEL_A_ADDR, 32'h3F3F_3F3F);
		wr(INT_SEL_HIGH_ADDR, '1);
		rd(INT_SEL_HIGH_ADDR, 32'h7FFF_7FFF);
		wr(XFER_SEL_A_ADDR, 32'h0302_0100);
		wr(INT_SEL_HIGH_ADDR, 32'h0820_2D43);
	endtask
	task automatic t_default();
		iv[1] <= 1'h1;
		resetReq <= 1'h1;
		nmiReq <= 1'h1;
		@(posedge mclk);
		{iv[1], resetReq, nmiReq} <= 3'h0;
		#1 chk(cpuIrq, 16'h4003);
		chk(xferTrigger, 16'h0002);
		repeat (2) @(posedge mclk);
		#1 chk(xferTrigger, 16'h0200);
	endtask
	task automatic t_int_codes();
		logic rsv;
		for (int c = 0; c < 32; c++) begin
			rsv = c inside {[17:21], [24:27]};
			if (c inside {[4:7], 16}) continue;
			wr(INT_SEL_LOW_ADDR, 32'h2507_18A0 | c);
			iv <= rsv ? '1 : 32'h1 << c;
			@(posedge mclk);
			iv <= '0;
			#1 chk(cpuIrq[4], !rsv);
			@(posedge mclk);
		end
		wr(INT_SEL_LOW_ADDR, 32'h2507_18A4);
	endtask
	task automatic t_xfer_codes();
		logic rsv;
		for (int c = 0; c < 64; c++) begin
			rsv = c inside {[16:31], [56:63]};
			if (c inside {[4:11], [48:55]}) continue;
			wr(XFER_SEL_D_ADDR, 32'h0F0E_0D00 | c);
			xv <= rsv ? '1 : 64'h1 << c;
			@(posedge mclk);
			xv <= '0;
			#1 chk(xferTrigger[12], !rsv);
			@(posedge mclk);
		end
	endtask
	// counts output pulses in a window longer than the pin sync delay
	task automatic edge_cnt(input int p, lvl, b, exp);
		int n;
		logic [31:0] o;
		n = 0;
		gpioPin[p] <= lvl[0];
		repeat (8) begin
			@(posedge mclk);
			#1 o = {xferTrigger, cpuIrq};
			n += o[b];
		end
		chk(n, exp);
	endtask
	task automatic t_gpio();
		edge_cnt(4, 1, 4, 1);
		edge_cnt(4, 0, 4, 0);
		wr(EXT_POL_ADDR, 32'h1);
		edge_cnt(4, 1, 4, 0);
		edge_cnt(4, 0, 20, 1);
		wr(XFER_SEL_D_ADDR, 32'h0F0E_0D31);
		edge_cnt(9, 1, 28, 1);
		wr(GPIO_COMB_EN_ADDR, 32'h1);
		wr(INT_SEL_HIGH_ADDR, 32'h0820_2D50);
		edge_cnt(0, 1, 10, 1);
		rd(PIN_LEVEL_ADDR, 32'h0201);
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'h1;
		t_regs();
		t_default();
		@(posedge mclk);
		t_int_codes();
		t_xfer_codes();
		t_gpio();
		report_and_stop();
	end
	initial begin
		#50000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
